/* design/tcr_pkg.sv */
// tcr_pkg: register map, field positions, reset values and encodings
// for the timer/counter control register block.
// assumes a 32-bit classic wishbone slave, one register per aligned word.
package tcr_pkg;

   // register index n sits at byte address 4*n on the bus
   localparam logic [4:0] IDX_MAIN_CONTROL = 5'h00;
   localparam logic [4:0] IDX_READ_SYNC_REQUEST = 5'h02;
   localparam logic [4:0] IDX_CONTROL_B_CLEAR = 5'h04;
   localparam logic [4:0] IDX_CONTROL_B_SET = 5'h05;
   localparam logic [4:0] IDX_CHANNEL_CONTROL = 5'h06;
   localparam logic [4:0] IDX_STATUS = 5'h0F;
   localparam logic [4:0] IDX_COUNT = 5'h10;
   localparam logic [4:0] IDX_PERIOD = 5'h14;
   localparam logic [4:0] IDX_COMPARE_ZERO = 5'h18;
   localparam logic [4:0] IDX_COMPARE_ONE = 5'h1C;
   localparam logic [4:0] IDX_SYNC_DATA = 5'h11;

   // main_control fields
   localparam int MC_SOFT_RESET = 0;
   localparam int MC_ENABLE = 1;
   localparam int MC_WIDTH_LSB = 2;
   localparam int MC_WAVE_LSB = 5;
   localparam logic [15:0] MC_WMASK = 16'h3F6F;
   localparam logic [15:0] MC_RESET = 16'h0000;

   // read_sync_request fields
   localparam int RQ_TRIGGER = 15;
   localparam int RQ_CONT = 14;
   localparam logic [15:0] RQ_WMASK = 16'h401F;

   // control_b, channel control and status fields
   localparam int CB_DIR = 0;
   localparam int CB_SINGLE = 2;
   localparam int CB_CMD_LSB = 6;
   localparam logic [7:0] CB_WMASK = 8'hC5;
   localparam logic [7:0] CC_WMASK = 8'h33;
   localparam int CC_INV_LSB = 0;
   localparam int CC_CAPT_LSB = 4;

   localparam int STATUS_BUSY = 7;
   localparam int STATUS_STOP = 3;

   typedef enum logic [1:0] {
      WAVE_NORMAL_FREQ = 2'b00,
      WAVE_MATCH_FREQ = 2'b01,
      WAVE_NORMAL_PWM = 2'b10,
      WAVE_MATCH_PWM = 2'b11
   } tcr_wave_type;

   typedef enum logic [1:0] {
      W_SIXTEEN = 2'b00,
      W_EIGHT = 2'b01,
      W_THIRTYTWO = 2'b10,
      W_RESERVED = 2'b11
   } tcr_width_type;

   typedef enum logic [1:0] {
      CMD_NONE = 2'b00,
      CMD_RETRIGGER = 2'b01,
      CMD_STOP = 2'b10,
      CMD_RESERVED = 2'b11
   } tcr_cmd_type;

   // wishbone request bundle
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [3:0] sel;
      logic [6:0] adr;
      logic [31:0] dat;
   } tcr_wb_req_type;

   // synchronizer handshake: a word is handed over with a toggle
   localparam int SYNC_STAGES = 2;
   localparam logic [2:0] PRESC_RESET = 3'h0;

endpackage : tcr_pkg

/* design/tcr_top.sv */
// tcr_top: control registers, write/read synchronisation and a compact
// counter with two compare channels and waveform outputs.
// assumes a classic wishbone master on clk_i; the counter side runs on
// a prescaled enable pulse, so the clock crossing is a toggle handshake
// within one clock and is modelled as a fixed busy latency.
`timescale 1ns/1ps

// Operation
// - freq ops toggle output on match only
// - pwm ops set/clear on wrap by direction
// - normal top: period in 8-bit, else max
// - width field picks 16, 8, 32 bits
// - enable reads back, busy until synced
// - soft reset restores registers except sync data, disables counter
// - soft reset write discards other bit changes
// - soft reset bit reads one until done
// - read trigger syncs addressed register, reads zero
// - continuous read resyncs on every update
// - clear and set addresses share control bits
// - command runs on next prescaled tick, clears
// - clear-address ones cancel pending command
// - single run stops at next wrap
// - single run set on, clear off
// - direction bit: set down, clear up
// - capture select makes channel capture input
// - output invert flips waveform pin
// - reserved bits read zero
// - protected fields writable only when disabled
module tcr_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [6:0] adr_i,
   input wire logic [31:0] dat_i,
   output logic [31:0] dat_o,
   output logic ack_o,
   // channel capture inputs
   input wire logic [1:0] capture_in_i,
   // waveform outputs and status
   output logic [1:0] waveform_out_pin_o,
   output logic counter_running_o
);

   logic [15:0] main_control_q;
   logic [15:0] read_sync_request_q;
   logic [7:0] control_b_q;
   logic [7:0] channel_control_q;
   logic [31:0] count_q;
   logic [31:0] period_value_q;
   logic [31:0] cc_q [2];
   logic [31:0] sync_data_q;
   logic [1:0] wave_q;
   logic [1:0] cap_prev_q;
   logic running_q;
   logic started_q;
   logic [2:0] presc_q;
   logic tick_q;
   logic [1:0] busy_cnt_q;
   logic soft_reset_bit_pend_q;
   logic ena_live_q;
   logic rsync_pend_q;
   logic ack_q;
   logic [31:0] dat_q;

   tcr_pkg::tcr_wb_req_type req;
   logic wr;
   logic rd;
   logic [4:0] idx;
   logic [31:0] wmask;
   logic busy;
   logic soft_reset_bit_wr;
   logic wrap;
   logic [31:0] top;
   logic [31:0] wdat;

   assign req = '{cyc: cyc_i, stb: stb_i, we: we_i, sel: sel_i,
                  adr: adr_i, dat: dat_i};
   assign idx = req.adr[6:2];
   assign wr = req.cyc && req.stb && req.we && !ack_q;
   assign rd = req.cyc && req.stb && !req.we && !ack_q;
   assign busy = busy_cnt_q != 2'h0;

   // byte lane mask from sel
   function automatic logic [31:0] lanes(input logic [3:0] s);
      lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
   endfunction : lanes

   function automatic logic [31:0] width_max(input logic [1:0] w);
      unique case (w)
         tcr_pkg::W_EIGHT: width_max = 32'h0000_00FF;
         tcr_pkg::W_THIRTYTWO: width_max = 32'hFFFF_FFFF;
         default: width_max = 32'h0000_FFFF;
      endcase
   endfunction : width_max

   assign wmask = lanes(req.sel);
   assign wdat = req.dat & wmask;
   assign soft_reset_bit_wr = wr && idx == tcr_pkg::IDX_MAIN_CONTROL &&
                     wdat[tcr_pkg::MC_SOFT_RESET];

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= req.cyc && req.stb && !ack_q;
      end
   end

   // sync busy: a write to a synced register holds busy two cycles
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_cnt_q <= 2'h0;
      end else if (soft_reset_bit_wr ||
                   (wr && (idx == tcr_pkg::IDX_MAIN_CONTROL ||
                    idx == tcr_pkg::IDX_CONTROL_B_CLEAR ||
                    idx == tcr_pkg::IDX_CONTROL_B_SET ||
                    idx == tcr_pkg::IDX_CHANNEL_CONTROL)) ||
                   (wr && idx == tcr_pkg::IDX_READ_SYNC_REQUEST &&
                    wdat[tcr_pkg::RQ_TRIGGER])) begin
         busy_cnt_q <= 2'h2;
      end else if (busy) begin
         busy_cnt_q <= busy_cnt_q - 2'h1;
      end
   end

   // soft reset pending flag reads through bit 0
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         soft_reset_bit_pend_q <= 1'b0;
      end else if (soft_reset_bit_wr) begin
         soft_reset_bit_pend_q <= 1'b1;
      end else if (busy_cnt_q == 2'h1) begin
         soft_reset_bit_pend_q <= 1'b0;
      end
   end

   // main control; protected fields only while disabled
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         main_control_q <= tcr_pkg::MC_RESET;
      end else if (soft_reset_bit_pend_q && busy_cnt_q == 2'h1) begin
         main_control_q <= tcr_pkg::MC_RESET;
      end else if (soft_reset_bit_wr) begin
         main_control_q[tcr_pkg::MC_ENABLE] <= 1'b0;
      end else if (wr && idx == tcr_pkg::IDX_MAIN_CONTROL) begin
         main_control_q[tcr_pkg::MC_ENABLE] <=
            wdat[tcr_pkg::MC_ENABLE] | (!req.sel[0] &
            main_control_q[tcr_pkg::MC_ENABLE]);
         if (!main_control_q[tcr_pkg::MC_ENABLE]) begin
            main_control_q[15:2] <= 14'(((req.dat[15:0] &
               tcr_pkg::MC_WMASK & wmask[15:0]) |
               (main_control_q & ~wmask[15:0])) >> 2);
         end
      end
   end

   // enable reaches the counter only after the sync delay
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ena_live_q <= 1'b0;
      end else if (busy_cnt_q == 2'h1) begin
         ena_live_q <= main_control_q[tcr_pkg::MC_ENABLE] &&
                       !soft_reset_bit_pend_q;
      end
   end

   // read request register; trigger is never stored
   always_ff @(posedge clk_i) begin
      if (rst_i || (soft_reset_bit_pend_q && busy_cnt_q == 2'h1)) begin
         read_sync_request_q <= 16'h0000;
      end else if (wr && !soft_reset_bit_pend_q &&
                   idx == tcr_pkg::IDX_READ_SYNC_REQUEST) begin
         read_sync_request_q <= (req.dat[15:0] & wmask[15:0] &
            tcr_pkg::RQ_WMASK & 16'h7FFF) |
            (read_sync_request_q & ~wmask[15:0]);
      end
   end

   // snapshot of the addressed register (count or compare only)
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rsync_pend_q <= 1'b0;
         sync_data_q <= 32'h0000_0000;
      end else begin
         if (wr && idx == tcr_pkg::IDX_READ_SYNC_REQUEST &&
             wdat[tcr_pkg::RQ_TRIGGER]) begin
            rsync_pend_q <= 1'b1;
         end else if (busy_cnt_q == 2'h1) begin
            rsync_pend_q <= 1'b0;
         end
         if ((rsync_pend_q && busy_cnt_q == 2'h1) ||
             (read_sync_request_q[tcr_pkg::RQ_CONT] && tick_q)) begin
            unique case (read_sync_request_q[4:0])
               tcr_pkg::IDX_COMPARE_ZERO: sync_data_q <= cc_q[0];
               tcr_pkg::IDX_COMPARE_ONE: sync_data_q <= cc_q[1];
               default: sync_data_q <= count_q;
            endcase
         end
      end
   end

   // control b through clear/set addresses; command cleared on run
   always_ff @(posedge clk_i) begin
      if (rst_i || (soft_reset_bit_pend_q && busy_cnt_q == 2'h1)) begin
         control_b_q <= 8'h00;
      end else if (wr && !soft_reset_bit_pend_q &&
                   idx == tcr_pkg::IDX_CONTROL_B_CLEAR) begin
         control_b_q <= control_b_q &
            ~(req.dat[7:0] & tcr_pkg::CB_WMASK);
      end else if (wr && !soft_reset_bit_pend_q &&
                   idx == tcr_pkg::IDX_CONTROL_B_SET) begin
         control_b_q <= control_b_q |
            (req.dat[7:0] & tcr_pkg::CB_WMASK);
      end else if (tick_q) begin
         control_b_q[7:6] <= 2'b00;
      end
   end

   // channel control, write-synced like the rest
   always_ff @(posedge clk_i) begin
      if (rst_i || (soft_reset_bit_pend_q && busy_cnt_q == 2'h1)) begin
         channel_control_q <= 8'h00;
      end else if (wr && !soft_reset_bit_pend_q && req.sel[0] &&
                   idx == tcr_pkg::IDX_CHANNEL_CONTROL) begin
         channel_control_q <= req.dat[7:0] & tcr_pkg::CC_WMASK;
      end
   end

   // period register (enable protection not applied)
   always_ff @(posedge clk_i) begin
      if (rst_i || (soft_reset_bit_pend_q && busy_cnt_q == 2'h1)) begin
         period_value_q <= 32'hFFFF_FFFF;
      end else if (wr && !soft_reset_bit_pend_q && idx == tcr_pkg::IDX_PERIOD) begin
         period_value_q <= wdat | (period_value_q & ~wmask);
      end
   end

   // prescaler: fixed divide by eight gives the counter tick
   always_ff @(posedge clk_i) begin
      if (rst_i || !ena_live_q) begin
         presc_q <= tcr_pkg::PRESC_RESET;
         tick_q <= 1'b0;
      end else begin
         presc_q <= presc_q + 3'h1;
         tick_q <= presc_q == 3'h7;
      end
   end

   assign top = ((main_control_q[6:5] == tcr_pkg::WAVE_MATCH_FREQ) ||
                 (main_control_q[6:5] == tcr_pkg::WAVE_MATCH_PWM)) ? cc_q[0] :
                (main_control_q[3:2] == tcr_pkg::W_EIGHT) ?
                period_value_q & 32'h0000_00FF :
                width_max(main_control_q[3:2]);
   assign wrap = control_b_q[tcr_pkg::CB_DIR] ? count_q == 32'h0000_0000
                                              : count_q >= top;

   // counter, run state, single run and commands; enable starts the
   // counter once, so a finished single run or a stop stays stopped until a retrigger command
   always_ff @(posedge clk_i) begin
      if (rst_i || !ena_live_q) begin
         count_q <= 32'h0000_0000;
         running_q <= 1'b0;
         started_q <= 1'b0;
      end else if (tick_q) begin
         started_q <= 1'b1;
         if (control_b_q[7:6] == tcr_pkg::CMD_STOP) begin
            running_q <= 1'b0;
         end else if (control_b_q[7:6] == tcr_pkg::CMD_RETRIGGER ||
                      !started_q) begin
            running_q <= 1'b1;
            count_q <= control_b_q[tcr_pkg::CB_DIR] ? top : 32'h0000_0000;
         end else if (running_q) begin
            if (wrap) begin
               count_q <= control_b_q[tcr_pkg::CB_DIR] ? top
                                                        : 32'h0000_0000;
               if (control_b_q[tcr_pkg::CB_SINGLE]) begin
                  running_q <= 1'b0;
               end
            end else if (control_b_q[tcr_pkg::CB_DIR]) begin
               count_q <= count_q - 32'h0000_0001;
            end else begin
               count_q <= count_q + 32'h0000_0001;
            end
         end
      end
   end

   // channels: compare from bus, or capture on rising input edge
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      always_ff @(posedge clk_i) begin
         if (rst_i || (soft_reset_bit_pend_q && busy_cnt_q == 2'h1)) begin
            cc_q[ch] <= 32'h0000_0000;
            cap_prev_q[ch] <= 1'b0;
         end else begin
            cap_prev_q[ch] <= capture_in_i[ch];
            if (channel_control_q[tcr_pkg::CC_CAPT_LSB + ch]) begin
               if (capture_in_i[ch] && !cap_prev_q[ch]) begin
                  cc_q[ch] <= count_q;
               end
            end else if (wr && !soft_reset_bit_pend_q &&
                         idx == (ch == 0 ? tcr_pkg::IDX_COMPARE_ZERO
                                         : tcr_pkg::IDX_COMPARE_ONE)) begin
               cc_q[ch] <= wdat | (cc_q[ch] & ~wmask);
            end
         end
      end

      // waveform generation per operation
      always_ff @(posedge clk_i) begin
         if (rst_i || !ena_live_q) begin
            wave_q[ch] <= 1'b0;
         end else if (tick_q && running_q &&
                      !channel_control_q[tcr_pkg::CC_CAPT_LSB + ch]) begin
            if (!main_control_q[6]) begin
               if (count_q == cc_q[ch]) begin
                  wave_q[ch] <= !wave_q[ch];
               end
            end else if (wrap) begin
               wave_q[ch] <= !control_b_q[tcr_pkg::CB_DIR];
            end else if (count_q == cc_q[ch]) begin
               wave_q[ch] <= control_b_q[tcr_pkg::CB_DIR];
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (rst_i) begin
            waveform_out_pin_o[ch] <= 1'b0;
         end else begin
            waveform_out_pin_o[ch] <= wave_q[ch] ^
               channel_control_q[tcr_pkg::CC_INV_LSB + ch];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         counter_running_o <= 1'b0;
      end else begin
         counter_running_o <= running_q;
      end
   end

   // read mux; unmapped words read zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_q <= 32'h0000_0000;
      end else if (rd) begin
         unique case (idx)
            tcr_pkg::IDX_MAIN_CONTROL:
               dat_q <= {16'h0000, main_control_q[15:1],
                         soft_reset_bit_pend_q};
            tcr_pkg::IDX_READ_SYNC_REQUEST:
               dat_q <= {16'h0000, read_sync_request_q};
            tcr_pkg::IDX_CONTROL_B_CLEAR, tcr_pkg::IDX_CONTROL_B_SET:
               dat_q <= {24'h00_0000, control_b_q};
            tcr_pkg::IDX_CHANNEL_CONTROL:
               dat_q <= {24'h00_0000, channel_control_q};
            tcr_pkg::IDX_STATUS:
               dat_q <= {24'h00_0000, busy, 3'h0, !running_q, 3'h0};
            tcr_pkg::IDX_COUNT, tcr_pkg::IDX_SYNC_DATA:
               dat_q <= sync_data_q;
            tcr_pkg::IDX_PERIOD: dat_q <= period_value_q;
            tcr_pkg::IDX_COMPARE_ZERO: dat_q <= cc_q[0];
            tcr_pkg::IDX_COMPARE_ONE: dat_q <= cc_q[1];
            default: dat_q <= 32'h0000_0000;
         endcase
      end
   end

   assign dat_o = dat_q;
   assign ack_o = ack_q;

endmodule : tcr_top

/* dv/tcr_monitor.sv */
// tcr_monitor: port-level assertions for the timer control registers.
// assumes classic wishbone with ack one cycle after the taken request.
`timescale 1ns/1ps
module tcr_monitor (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // wishbone slave side
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [3:0] sel_i,
   input wire logic [6:0] adr_i,
   input wire logic [31:0] dat_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   // pins
   input wire logic [1:0] waveform_out_pin_o,
   input wire logic counter_running_o
);
   default clocking mon_cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic rd;
   logic wr0;
   logic [4:0] ix;
   assign ix = adr_i[6:2];
   assign rd = ack_o && !we_i;
   // only a write carrying byte 0 can touch the control bits
   assign wr0 = ack_o && we_i && sel_i[0] && ix == tcr_pkg::IDX_MAIN_CONTROL;
   sequence s_run_then_stop;
      counter_running_o ##[1:6] !counter_running_o;
   endsequence
   property p_ack_answer;
      cyc_i && stb_i && !ack_o |=> ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer)
      else $error("no ack one cycle after request");
   property p_ack_pulse;
      ack_o |=> !ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack longer than one cycle");
   property p_ack_idle;
      !(cyc_i && stb_i) |=> !ack_o;
   endproperty
   a_ack_idle: assert property (p_ack_idle)
      else $error("ack without request");
   property p_mc_rsvd;
      rd && ix == tcr_pkg::IDX_MAIN_CONTROL
         |-> (dat_o & ~{16'h0000, tcr_pkg::MC_WMASK}) == 32'h0000_0000;
   endproperty
   a_mc_rsvd: assert property (p_mc_rsvd)
      else $error("main control reserved bits nonzero");
   property p_rq_read;
      rd && ix == tcr_pkg::IDX_READ_SYNC_REQUEST
         |-> (dat_o & ~{16'h0000, tcr_pkg::RQ_WMASK}) == 32'h0000_0000;
   endproperty
   a_rq_read: assert property (p_rq_read)
      else $error("read request trigger or reserved bits read one");
   property p_cb_rsvd;
      rd && (ix == tcr_pkg::IDX_CONTROL_B_CLEAR
         || ix == tcr_pkg::IDX_CONTROL_B_SET)
         |-> (dat_o & ~{24'h00_0000, tcr_pkg::CB_WMASK}) == 32'h0000_0000;
   endproperty
   a_cb_rsvd: assert property (p_cb_rsvd)
      else $error("control b reserved bits nonzero");
   property p_cc_rsvd;
      rd && ix == tcr_pkg::IDX_CHANNEL_CONTROL
         |-> (dat_o & ~{24'h00_0000, tcr_pkg::CC_WMASK}) == 32'h0000_0000;
   endproperty
   a_cc_rsvd: assert property (p_cc_rsvd)
      else $error("channel control reserved bits nonzero");
   property p_soft_reset_bit;
      wr0 && dat_i[0] |-> ##[1:8] !counter_running_o;
   endproperty
   a_soft_reset_bit: assert property (p_soft_reset_bit)
      else $error("soft reset did not stop counter");
   property p_disable;
      wr0 && !dat_i[1] && !dat_i[0] && counter_running_o
         |=> s_run_then_stop;
   endproperty
   a_disable: assert property (p_disable)
      else $error("disable not delayed by sync or not taken");
endmodule : tcr_monitor

bind tcr_top tcr_monitor u_mon (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i,
   .sel_i, .adr_i, .dat_i, .dat_o, .ack_o, .waveform_out_pin_o,
   .counter_running_o);

/* dv/tb.sv */
// tb: self-checking bench for the timer control register block.
// assumes the design's hand-over timing: ack one cycle after a request.
`timescale 1ns/1ps
module tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc_i = 1'b0;
   logic stb_i = 1'b0;
   logic we_i = 1'b0;
   logic [3:0] sel_i = 4'h0;
   logic [6:0] adr_i = 7'h00;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [1:0] capture_in_i = 2'b00;
   logic [31:0] dat_o;
   logic ack_o;
   logic [1:0] waveform_out_pin_o;
   logic counter_running_o;
   int num_errors = 0;
   int checks_done = 0;
   logic [31:0] rd_q;
   always #50 clk_i = ~clk_i;
   tcr_top uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .sel_i, .adr_i,
      .dat_i, .dat_o, .ack_o, .capture_in_i, .waveform_out_pin_o,
      .counter_running_o);
   task test_done;
      $display("errors %0d checks %0d", num_errors, checks_done);
      if (num_errors == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : test_done
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // one classic cycle; read data is taken at the ack edge only
   task wb(input logic [4:0] ix, input logic w, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      sel_i <= 4'hF;
      adr_i <= {ix, 2'b00};
      dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 16);
      rd_q = dat_o;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      if (ack_o !== 1'b1) begin
         num_errors++;
         test_done();
      end
   endtask : wb
   task wait_run(input logic v);
      int n;
      n = 0;
      while (counter_running_o !== v && n < 128) begin
         @(posedge clk_i);
         n++;
      end
      check({31'h0, counter_running_o}, {31'h0, v});
   endtask : wait_run
   // set and clear views of control b; commands excluded, they self-clear
   function automatic logic [7:0] f_cb(logic [7:0] o, logic [7:0] d,
      logic s);
      return s ? (o | (d & 8'h05)) : (o & ~(d & 8'h05));
   endfunction : f_cb
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      test_done();
   end
   initial begin
      int i;
      logic [31:0] r;
      logic [31:0] s;
      logic [7:0] cb_m;
      r = $urandom(32'h0b04_24fc);
      cb_m = 8'h00;
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      // indexes 1 and 3 are unmapped
      for (i = 0; i < 7; i++) begin
         wb(5'(i), 1'b0, 32'h0000_0000);
         check(rd_q, 32'h0000_0000);
      end
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         capture_in_i <= r[9:8];
         r = r & {24'h0, tcr_pkg::CC_WMASK};
         wb(tcr_pkg::IDX_CHANNEL_CONTROL, 1'b1, r);
         wb(tcr_pkg::IDX_CHANNEL_CONTROL, 1'b0, 32'h0000_0000);
         check(rd_q, r);
      end
      // counter never ran, so the pins show the invert bits alone
      for (i = 0; i < 4; i++) begin
         wb(tcr_pkg::IDX_CHANNEL_CONTROL, 1'b1, 32'(i));
         repeat (4) @(posedge clk_i);
         check({30'h0, waveform_out_pin_o}, 32'(i));
      end
      wb(tcr_pkg::IDX_CHANNEL_CONTROL, 1'b1, 32'h0000_0000);
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         cb_m = f_cb(cb_m, r[7:0], r[8]);
         wb(5'h04 + {4'h0, r[8]}, 1'b1, r & 32'h0000_0005);
         wb(tcr_pkg::IDX_CONTROL_B_CLEAR, 1'b0, 32'h0000_0000);
         check(rd_q, {24'h0, cb_m});
         wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b0, 32'h0000_0000);
         check(rd_q, {24'h0, cb_m});
      end
      wb(tcr_pkg::IDX_CONTROL_B_CLEAR, 1'b1, 32'h0000_0005);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0080);
      wb(tcr_pkg::IDX_CONTROL_B_CLEAR, 1'b1, 32'h0000_00C0);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b0, 32'h0000_0000);
      check(rd_q, 32'h0000_0000);
      for (i = 0; i < 12; i++) begin
         r = {27'h0, 2'(i % 4), 1'b0, 2'(i / 4)} << 2;
         wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, r);
         wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b0, 32'h0000_0000);
         check(rd_q, r);
      end
      // 8-bit width: top is the period, so a single run ends quickly
      wb(tcr_pkg::IDX_PERIOD, 1'b1, 32'h0000_0004);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0004);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_0006);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b0, 32'h0000_0000);
      check(rd_q, 32'h0000_0006);
      wait_run(1'b1);
      wait_run(1'b0);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_0062);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b0, 32'h0000_0000);
      check(rd_q, 32'h0000_0006);
      wb(tcr_pkg::IDX_CONTROL_B_CLEAR, 1'b1, 32'h0000_0004);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0040);
      wait_run(1'b1);
      repeat (60) @(posedge clk_i);
      check({31'h0, counter_running_o}, 32'h0000_0001);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b0, 32'h0000_0000);
      check(rd_q, 32'h0000_0000);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0080);
      wait_run(1'b0);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0040);
      wait_run(1'b1);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_0000);
      wait_run(1'b0);
      wb(tcr_pkg::IDX_STATUS, 1'b0, 32'h0000_0000);
      check({31'h0, rd_q[7]}, 32'h0000_0000);
      // soft reset while running; the other bits in that write are lost
      wb(tcr_pkg::IDX_CHANNEL_CONTROL, 1'b1, 32'h0000_0033);
      wb(tcr_pkg::IDX_CONTROL_B_SET, 1'b1, 32'h0000_0005);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_0006);
      wait_run(1'b1);
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_006B);
      wait_run(1'b0);
      repeat (8) @(posedge clk_i);
      for (i = 0; i < 7; i++) begin
         wb(5'(i), 1'b0, 32'h0000_0000);
         check(rd_q, 32'h0000_0000);
      end
      wb(tcr_pkg::IDX_PERIOD, 1'b0, 32'h0000_0000);
      check(rd_q, 32'hFFFF_FFFF);
      // one-shot sync of compare zero, then continuous sync of the count
      r = 32'h0000_0002 + ($urandom & 32'h0000_0003);
      wb(tcr_pkg::IDX_COMPARE_ZERO, 1'b1, r);
      wb(tcr_pkg::IDX_READ_SYNC_REQUEST, 1'b1, 32'h0000_8018);
      wb(tcr_pkg::IDX_COUNT, 1'b0, 32'h0000_0000);
      check(rd_q, r);
      wb(tcr_pkg::IDX_READ_SYNC_REQUEST, 1'b0, 32'h0000_0000);
      check(rd_q, 32'h0000_0018);
      wb(tcr_pkg::IDX_READ_SYNC_REQUEST, 1'b1, 32'h0000_4010);
      // 16-bit frequency op: each pin toggles once on its first match
      wb(tcr_pkg::IDX_MAIN_CONTROL, 1'b1, 32'h0000_0002);
      repeat (100) @(posedge clk_i);
      check({30'h0, waveform_out_pin_o}, 32'h0000_0003);
      wb(tcr_pkg::IDX_COUNT, 1'b0, 32'h0000_0000);
      s = rd_q;
      repeat (16) @(posedge clk_i);
      wb(tcr_pkg::IDX_COUNT, 1'b0, 32'h0000_0000);
      check({31'h0, rd_q > s}, 32'h0000_0001);
      test_done();
   end
endmodule : tb
